// ---- logic/nv_pkg.sv ----
// Shared constants for the data EEPROM access sequencer and its controller.
// Notes on behaviour
// - Write-start follows write-enable in the next instruction.
// - Interrupts off before a write, on after start.
// - Low-power entry during a cycle aborts it.
// - Keep write-enable cleared outside intended writes.
// - Control register reachable only through bank one.
// - Pointer 040H and bank 01H reach control register.
// - Read: address, read-enable bit 1, read-start bit 0.
// - Poll read-start to zero, then take data.
// - Write: address, data, write-enable bit 3, start bit 2.
// - Poll write-start to zero, clear control, bank zero.
// - Optionally read back and compare written byte.
// - Start bits self-clear; need enable already set.
// - Never both starts, nor enable with start.
// - Write end sets done and shared flags.
// - Power-on clears write-enable and bank select.
package nv_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int READ_TIME_NS = 250;
    localparam int WRITE_TIME_NS = 100000;
    localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam int NV_DEPTH = 128;
    localparam int NV_AW = 7;
    localparam logic [7:0] NV_ERASED = 8'hFF;
    // Data-memory locations on the link.
    localparam logic [7:0] SFR_IAR = 8'h02;
    localparam logic [7:0] SFR_MP = 8'h03;
    localparam logic [7:0] SFR_BANK = 8'h04;
    localparam logic [7:0] SFR_NV_ADDR = 8'h05;
    localparam logic [7:0] SFR_NV_DATA = 8'h06;
    localparam logic [7:0] SFR_INTC = 8'h07;
    localparam logic [7:0] CTRL_OFFSET = 8'h40;
    localparam logic [7:0] BANK_ONE = 8'h01;
    localparam logic [7:0] BANK_ZERO = 8'h00;
    // Control register fields and reset values.
    localparam logic [7:0] CTRL_RD = 8'h01;
    localparam logic [7:0] CTRL_RD_EN = 8'h02;
    localparam logic [7:0] CTRL_WR = 8'h04;
    localparam logic [7:0] CTRL_WR_EN = 8'h08;
    localparam logic [7:0] CTRL_USED = 8'h0F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [7:0] INTC_DONE_IE = 8'h01;
    localparam logic [7:0] INTC_DONE_FLAG = 8'h02;
    // Controller register map on APB.
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_ADDR = 12'h004;
    localparam logic [11:0] APB_WDATA = 12'h008;
    localparam logic [11:0] APB_STATUS = 12'h00C;
    localparam logic [11:0] APB_INT_STATUS = 12'h010;
    localparam logic [11:0] APB_INT_MASK = 12'h014;
    localparam int CMD_READ_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_VERIFY_BIT = 2;
    localparam int CMD_SLEEP_BIT = 3;
    localparam int EV_READ_DONE = 0;
    localparam int EV_WRITE_DONE = 1;
    localparam int EV_VERIFY_ERR = 2;
    localparam logic [3:0] WR_START_STEP = 4'h5;
endpackage

// ---- logic/nv_link_if.sv ----
// Link between the processor-side controller and the EEPROM access block.
`timescale 1ns/10ps
interface nv_link_if;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic gie;
    logic sleep;
    logic irq_ack;
    logic irq;
    modport host (output req, output wr, output addr, output wdata, output gie,
        output sleep, output irq_ack, input rdata, input ack, input irq);
    modport device (input req, input wr, input addr, input wdata, input gie,
        input sleep, input irq_ack, output rdata, output ack, output irq);
endinterface

// ---- logic/nv_cell_array.sv ----
// Byte-wide nonvolatile cell array with timed read and write cycles.
`timescale 1ns/10ps
module nv_cell_array import nv_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start_rd,
    input wire logic start_wr,
    input wire logic abort,
    input wire logic [NV_AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic done_rd,
    output logic done_wr,
    output logic [7:0] rdata
);
    typedef enum logic [1:0] {A_IDLE, A_READ, A_WRITE} arr_state_e;
    typedef struct packed {
        arr_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [NV_AW-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done_rd;
        logic done_wr;
        logic [NV_DEPTH-1:0][7:0] mem;
    } arr_s;
    arr_s q, d;

    always_comb
    begin
        d = q;
        d.done_rd = 1'b0;
        d.done_wr = 1'b0;
        case (q.st)
            A_IDLE:
            begin
                d.addr = addr;
                d.wdata = wdata;
                if (start_rd)
                begin
                    d.st = A_READ;
                    d.cnt = CNT_W'(READ_CYCLES - 1);
                end
                else if (start_wr)
                begin
                    d.st = A_WRITE;
                    d.cnt = CNT_W'(WRITE_CYCLES - 1);
                end
            end
            A_READ, A_WRITE:
            begin
                // An abort leaves the cell untouched and reports no completion.
                if (abort)
                    d.st = A_IDLE;
                else if (q.cnt == '0)
                begin
                    d.st = A_IDLE;
                    if (q.st == A_READ)
                    begin
                        d.rdata = q.mem[q.addr];
                        d.done_rd = 1'b1;
                    end
                    else
                    begin
                        d.mem[q.addr] = q.wdata;
                        d.done_wr = 1'b1;
                    end
                end
                else
                    d.cnt = q.cnt - 1'b1;
            end
            default:
                d.st = A_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.st <= A_IDLE;
            q.mem <= {NV_DEPTH{NV_ERASED}};
        end
        else
            q <= d;
    end

    assign busy = (q.st != A_IDLE);
    assign done_rd = q.done_rd;
    assign done_wr = q.done_wr;
    assign rdata = q.rdata;
endmodule // nv_cell_array

// ---- logic/nv_device.sv ----
// EEPROM access block: address, data, control and interrupt registers.
`timescale 1ns/10ps
module nv_device import nv_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    nv_link_if.device link,
    output logic nv_busy
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] bank;
        logic [7:0] mp;
        logic [7:0] ea;
        logic [7:0] ed;
        logic done_ie;
        logic done_flag;
        logic mfi;
        logic ack;
        logic [7:0] rdata;
        logic irq;
        logic busy;
    } dev_s;
    dev_s q, d;
    logic arr_busy, done_rd, done_wr, start_rd, start_wr, abort;
    logic [7:0] arr_rdata;

    function automatic logic ctrl_reachable(logic [7:0] bank, logic [7:0] mp);
        return (bank == BANK_ONE) && (mp == CTRL_OFFSET);
    endfunction

    nv_cell_array u_cells (
        .clk(clk),
        .reset_n(reset_n),
        .start_rd(start_rd),
        .start_wr(start_wr),
        .abort(abort),
        .addr(q.ea[NV_AW-1:0]),
        .wdata(q.ed),
        .busy(arr_busy),
        .done_rd(done_rd),
        .done_wr(done_wr),
        .rdata(arr_rdata)
    );

    always_comb
    begin
        logic [7:0] nw;
        logic hit;
        nw = '0;
        hit = link.req && !q.ack;
        d = q;
        d.ack = 1'b0;
        start_rd = 1'b0;
        start_wr = 1'b0;
        abort = 1'b0;
        if (hit)
        begin
            d.ack = 1'b1;
            case (link.addr)
                SFR_IAR: d.rdata = ctrl_reachable(q.bank, q.mp) ? q.ctrl : '0;
                SFR_MP: d.rdata = q.mp;
                SFR_BANK: d.rdata = q.bank;
                SFR_NV_ADDR: d.rdata = q.ea;
                SFR_NV_DATA: d.rdata = q.ed;
                SFR_INTC: d.rdata = {6'h00, q.done_flag, q.done_ie};
                default: d.rdata = '0;
            endcase
            if (link.wr)
            begin
                case (link.addr)
                    SFR_IAR:
                    begin
                        // Outside bank one the indirect port writes nothing.
                        if (ctrl_reachable(q.bank, q.mp))
                        begin
                            nw = link.wdata & CTRL_USED;
                            // A start bit is held while its cycle runs.
                            nw = nw | (q.ctrl & (CTRL_RD | CTRL_WR));
                            // A new start needs its enable set beforehand.
                            if (!q.ctrl[0] && !q.ctrl[2] && !arr_busy)
                            begin
                                if (link.wdata[0] && q.ctrl[1])
                                    start_rd = 1'b1;
                                else if (link.wdata[2] && q.ctrl[3])
                                    start_wr = 1'b1;
                            end
                            nw = (nw & ~(CTRL_RD | CTRL_WR)) | (q.ctrl & (CTRL_RD | CTRL_WR));
                            if (start_rd)
                                nw = nw | CTRL_RD;
                            if (start_wr)
                                nw = nw | CTRL_WR;
                            d.ctrl = nw;
                        end
                    end
                    SFR_MP: d.mp = link.wdata;
                    SFR_BANK: d.bank = link.wdata;
                    SFR_NV_ADDR: d.ea = {1'b0, link.wdata[NV_AW-1:0]};
                    SFR_NV_DATA: d.ed = link.wdata;
                    SFR_INTC:
                    begin
                        d.done_ie = link.wdata[0];
                        d.done_flag = link.wdata[1];
                    end
                    default: d.ed = q.ed;
                endcase
            end
        end
        // Sleep during a cycle kills it; the start bits drop with no result.
        if (link.sleep && (q.ctrl[0] || q.ctrl[2]))
        begin
            abort = 1'b1;
            d.ctrl = d.ctrl & ~(CTRL_RD | CTRL_WR);
        end
        if (link.irq_ack)
            d.mfi = 1'b0;
        if (done_rd)
        begin
            d.ctrl = d.ctrl & ~CTRL_RD;
            d.ed = arr_rdata;
        end
        // Completion is applied last so it wins over a clear in the same cycle.
        if (done_wr)
        begin
            d.ctrl = d.ctrl & ~CTRL_WR;
            d.done_flag = 1'b1;
            d.mfi = 1'b1;
        end
        d.irq = q.mfi && q.done_ie && link.gie;
        d.busy = arr_busy;
    end

    // Reset leaves write-enable clear and bank zero selected.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
            q.bank <= BANK_ZERO;
            q.mp <= REG8_RESET;
            q.ea <= REG8_RESET;
            q.ed <= REG8_RESET;
        end
        else
            q <= d;
    end

    assign link.ack = q.ack;
    assign link.rdata = q.rdata;
    assign link.irq = q.irq;
    assign nv_busy = q.busy;
endmodule // nv_device

// ---- logic/nv_host.sv ----
// Processor-side controller that runs EEPROM read and write sequences for software.
`timescale 1ns/10ps
module nv_host import nv_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    nv_link_if.host link
);
    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_state_e;
    typedef struct packed {
        logic wr;
        logic poll;
        logic last;
        logic [7:0] a;
        logic [7:0] dat;
    } op_s;
    typedef struct packed {
        host_state_e st;
        logic [3:0] step;
        logic kind_wr;
        logic verify_phase;
        logic verify_opt;
        logic sleep_req;
        logic verify_err;
        logic [NV_AW-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] rd_data;
        logic [2:0] int_status;
        logic [2:0] int_mask;
        logic req;
        logic wr;
        logic [7:0] laddr;
        logic [7:0] lwdata;
        logic gie;
        logic sleep;
        logic irq_ack;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } host_s;
    host_s q, d;

    function automatic op_s mk(logic wr, logic poll, logic last, logic [7:0] a, logic [7:0] v);
        op_s o;
        o.wr = wr;
        o.poll = poll;
        o.last = last;
        o.a = a;
        o.dat = v;
        return o;
    endfunction

    // One link instruction per step; a poll step repeats while its bit reads one.
    function automatic op_s seq_op(logic is_wr, logic [3:0] step, logic [7:0] a,
        logic [7:0] v);
        op_s o;
        o = '0;
        if (!is_wr)
        begin
            case (step)
                4'h0: o = mk(1'b1, 1'b0, 1'b0, SFR_NV_ADDR, a);
                4'h1: o = mk(1'b1, 1'b0, 1'b0, SFR_MP, CTRL_OFFSET);
                4'h2: o = mk(1'b1, 1'b0, 1'b0, SFR_BANK, BANK_ONE);
                4'h3: o = mk(1'b1, 1'b0, 1'b0, SFR_IAR, CTRL_RD_EN);
                4'h4: o = mk(1'b1, 1'b0, 1'b0, SFR_IAR, CTRL_RD_EN | CTRL_RD);
                4'h5: o = mk(1'b0, 1'b1, 1'b0, SFR_IAR, CTRL_RD);
                4'h6: o = mk(1'b1, 1'b0, 1'b0, SFR_IAR, CTRL_RESET);
                4'h7: o = mk(1'b1, 1'b0, 1'b0, SFR_BANK, BANK_ZERO);
                default: o = mk(1'b0, 1'b0, 1'b1, SFR_NV_DATA, REG8_RESET);
            endcase
        end
        else
        begin
            case (step)
                4'h0: o = mk(1'b1, 1'b0, 1'b0, SFR_NV_ADDR, a);
                4'h1: o = mk(1'b1, 1'b0, 1'b0, SFR_NV_DATA, v);
                4'h2: o = mk(1'b1, 1'b0, 1'b0, SFR_MP, CTRL_OFFSET);
                4'h3: o = mk(1'b1, 1'b0, 1'b0, SFR_BANK, BANK_ONE);
                4'h4: o = mk(1'b1, 1'b0, 1'b0, SFR_IAR, CTRL_WR_EN);
                // Issued as the very next instruction after write-enable.
                4'h5: o = mk(1'b1, 1'b0, 1'b0, SFR_IAR, CTRL_WR_EN | CTRL_WR);
                4'h6: o = mk(1'b0, 1'b1, 1'b0, SFR_IAR, CTRL_WR);
                4'h7: o = mk(1'b1, 1'b0, 1'b0, SFR_IAR, CTRL_RESET);
                4'h8: o = mk(1'b1, 1'b0, 1'b0, SFR_BANK, BANK_ZERO);
                default: o = mk(1'b1, 1'b0, 1'b1, SFR_INTC, INTC_DONE_IE);
            endcase
        end
        return o;
    endfunction

    always_comb
    begin
        op_s o;
        logic [2:0] ev;
        logic setup;
        logic access;
        o = seq_op(q.kind_wr, q.step, {1'b0, q.addr}, q.wdata);
        ev = '0;
        setup = psel && !penable;
        access = psel && penable && q.pready;
        d = q;
        d.irq_ack = link.irq && !q.irq_ack;
        case (q.st)
            H_IDLE:
                d.step = '0;
            H_ISSUE:
            begin
                d.req = 1'b1;
                d.wr = o.wr;
                d.laddr = o.a;
                d.lwdata = o.dat;
                d.st = H_WAIT;
            end
            H_WAIT:
            begin
                if (q.req && link.ack)
                begin
                    d.req = 1'b0;
                    d.st = H_ISSUE;
                    // Interrupts return only once the write cycle has started.
                    if (q.kind_wr && q.step == WR_START_STEP)
                        d.gie = 1'b1;
                    if (o.poll && ((link.rdata & o.dat) != '0))
                        d.step = q.step;
                    else if (!o.last)
                        d.step = q.step + 1'b1;
                    else if (q.kind_wr)
                    begin
                        ev[EV_WRITE_DONE] = 1'b1;
                        d.step = '0;
                        // Read the new byte back and compare it.
                        if (q.verify_opt)
                        begin
                            d.kind_wr = 1'b0;
                            d.verify_phase = 1'b1;
                        end
                        else
                            d.st = H_IDLE;
                    end
                    else
                    begin
                        d.rd_data = link.rdata;
                        d.st = H_IDLE;
                        d.verify_phase = 1'b0;
                        if (q.verify_phase)
                        begin
                            d.verify_err = (link.rdata != q.wdata);
                            ev[EV_VERIFY_ERR] = (link.rdata != q.wdata);
                        end
                        else
                            ev[EV_READ_DONE] = 1'b1;
                    end
                end
            end
            default:
                d.st = H_IDLE;
        endcase
        d.pslverr = 1'b0;
        d.pready = 1'b0;
        if (setup)
        begin
            d.pready = 1'b1;
            d.prdata = '0;
            case (paddr)
                APB_CMD: d.prdata[CMD_SLEEP_BIT:CMD_VERIFY_BIT] = {q.sleep_req, q.verify_opt};
                APB_ADDR: d.prdata[NV_AW-1:0] = q.addr;
                APB_WDATA: d.prdata[7:0] = q.wdata;
                APB_STATUS: d.prdata[15:0] = {q.rd_data, 5'h00, q.verify_err, q.sleep,
                    q.st != H_IDLE};
                APB_INT_STATUS: d.prdata[2:0] = q.int_status;
                APB_INT_MASK: d.prdata[2:0] = q.int_mask;
                default: d.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite)
        begin
            case (paddr)
                APB_CMD:
                begin
                    d.verify_opt = pwdata[CMD_VERIFY_BIT];
                    d.sleep_req = pwdata[CMD_SLEEP_BIT];
                    // Starts are taken only when idle; one kind at a time.
                    if (q.st == H_IDLE && pwdata[CMD_READ_BIT])
                    begin
                        d.st = H_ISSUE;
                        d.kind_wr = 1'b0;
                        d.verify_phase = 1'b0;
                    end
                    else if (q.st == H_IDLE && pwdata[CMD_WRITE_BIT])
                    begin
                        d.st = H_ISSUE;
                        d.kind_wr = 1'b1;
                        d.verify_phase = 1'b0;
                        d.verify_err = 1'b0;
                        d.gie = 1'b0;
                    end
                end
                APB_ADDR: d.addr = pwdata[NV_AW-1:0];
                APB_WDATA: d.wdata = pwdata[7:0];
                APB_INT_STATUS: d.int_status = q.int_status & ~pwdata[2:0];
                APB_INT_MASK: d.int_mask = pwdata[2:0];
                default: d.addr = q.addr;
            endcase
        end
        // Events are merged after the clear so a same-cycle event survives.
        d.int_status = d.int_status | ev;
        // Low power is offered to the device only while no sequence runs.
        d.sleep = d.sleep_req && (d.st == H_IDLE);
        d.irq = |(d.int_status & d.int_mask);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.st <= H_IDLE;
            q.gie <= 1'b1;
        end
        else
            q <= d;
    end

    assign link.req = q.req;
    assign link.wr = q.wr;
    assign link.addr = q.laddr;
    assign link.wdata = q.lwdata;
    assign link.gie = q.gie;
    assign link.sleep = q.sleep;
    assign link.irq_ack = q.irq_ack;
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
endmodule // nv_host

// ---- bench/nv_link_sva.sv ----
// Concurrent checks on the link between the controller and the access block.
`timescale 1ns/10ps
module nv_link_sva import nv_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic gie,
    input wire logic sleep,
    input wire logic irq_ack,
    input wire logic irq,
    input wire logic nv_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_port_wr(logic [7:0] v);
        req && wr && addr == SFR_IAR && wdata == v;
    endsequence
    sequence s_port_done(logic [7:0] v);
        s_port_wr(v) ##0 ack;
    endsequence
    a_ack_after_req: assert property (req && !ack |=> ack)
        else $error("link request not answered in the next cycle");
    a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
        else $error("link request changed before its answer");
    a_ack_single: assert property (ack |-> $past(req) ##1 !ack)
        else $error("answer without request or longer than one cycle");
    a_gie_off_write: assert property (s_port_wr(CTRL_WR_EN) |-> !gie)
        else $error("interrupts enabled while arming a write");
    a_gie_back_on: assert property (s_port_done(CTRL_WR_EN | CTRL_WR) |=> gie)
        else $error("interrupts not enabled after write start");
    a_start_follows: assert property (s_port_done(CTRL_WR_EN) |=> !req ##1
        s_port_wr(CTRL_WR_EN | CTRL_WR))
        else $error("write start does not follow write enable");
    a_read_busy: assert property (s_port_done(CTRL_RD_EN | CTRL_RD) |-> ##[0:2] nv_busy)
        else $error("read start did not begin a cell cycle");
    a_write_busy: assert property (s_port_done(CTRL_WR_EN | CTRL_WR) |-> ##[0:2] nv_busy)
        else $error("write start did not begin a cell cycle");
    a_sleep_idle: assert property ($rose(sleep) |-> !nv_busy)
        else $error("low power requested during a cell cycle");
    a_irq_service: assert property ($rose(irq) |-> ##[1:3] irq_ack)
        else $error("write done interrupt not serviced");
    a_irq_clears: assert property (irq_ack |-> ##[1:3] !irq)
        else $error("shared flag not cleared by service");
endmodule // nv_link_sva

// ---- bench/testbench.sv ----
// Self-checking bench for the controller and access block joined over the link.
`timescale 1ns/10ps
module testbench import nv_pkg::*; ;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic nv_busy;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int checked = 0;
    nv_link_if lk();
    nv_host i_nv_host(.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(lk));
    nv_device i_nv_device(.clk(clk), .reset_n(reset_n), .link(lk), .nv_busy(nv_busy));
    nv_link_sva i_nv_link_sva(.clk(clk), .reset_n(reset_n), .req(lk.req), .wr(lk.wr),
        .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .gie(lk.gie), .sleep(lk.sleep),
        .irq_ack(lk.irq_ack), .irq(lk.irq), .nv_busy(nv_busy));
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Called right after a rising edge; ends one idle cycle after the access.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk(32'(pready), 32'h0000_0001);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, APB_STATUS, 32'h0000_0000);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 1500);
        chk(32'(rd[0]), 32'h0000_0000);
    endtask
    task automatic t_reset();
        apb(1'b0, APB_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(i_nv_device.q.ctrl), 32'h0000_0000);
        chk(32'(i_nv_device.q.bank), 32'h0000_0000);
        apb(1'b0, 12'h018, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
    endtask
    task automatic t_read();
        apb(1'b1, APB_INT_MASK, 32'h0000_0002);
        apb(1'b1, APB_ADDR, 32'h0000_007F);
        apb(1'b1, APB_CMD, 32'h0000_0001);
        wait_idle();
        chk({24'h00_0000, rd[15:8]}, 32'h0000_00FF);
        apb(1'b0, APB_INT_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, APB_INT_STATUS, 32'h0000_0001);
    endtask
    task automatic t_write();
        int n;
        n = 0;
        apb(1'b1, APB_WDATA, 32'h0000_00A5);
        apb(1'b1, APB_CMD, 32'h0000_0002);
        apb(1'b1, APB_CMD, 32'h0000_0001);
        while (irq !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b0, APB_INT_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        chk(32'(i_nv_device.q.ctrl), 32'h0000_0000);
        chk(32'(i_nv_device.q.bank), 32'h0000_0000);
        chk(32'(i_nv_device.q.mfi), 32'h0000_0000);
        apb(1'b1, APB_INT_STATUS, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, APB_CMD, 32'h0000_0001);
        wait_idle();
        chk({24'h00_0000, rd[15:8]}, 32'h0000_00A5);
    endtask
    task automatic t_verify();
        apb(1'b1, APB_ADDR, 32'h0000_0000);
        apb(1'b1, APB_WDATA, 32'h0000_003C);
        apb(1'b1, APB_CMD, 32'h0000_0006);
        wait_idle();
        chk(32'(rd[2]), 32'h0000_0000);
        apb(1'b0, APB_INT_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0006, 32'h0000_0002);
        apb(1'b1, APB_INT_STATUS, 32'h0000_0007);
        apb(1'b1, APB_CMD, 32'h0000_0000);
    endtask
    task automatic t_sleep();
        apb(1'b1, APB_CMD, 32'h0000_0008);
        apb(1'b0, APB_CMD, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        chk(32'(lk.sleep), 32'h0000_0001);
        apb(1'b1, APB_CMD, 32'h0000_0000);
        chk(32'(lk.sleep), 32'h0000_0000);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_read();
        t_write();
        t_verify();
        t_sleep();
        final_report();
    end
endmodule // testbench
